/* vfs_cfg.svh */
`ifndef VFS_CFG_SVH
`define VFS_CFG_SVH
// Command code and page values.
`define VFS_CMD_CODE 8'h80
`define VFS_PAGE_A 8'h00
`define VFS_PAGE_B 8'h01
`define VFS_PAGE_ALL 8'hFF
// Bit positions inside the status byte.
`define VFS_BIT_PS 7
`define VFS_BIT_SNS 6
`define VFS_BIT_PHL 5
`define VFS_BIT_TMP 4
`define VFS_BIT_VCR 3
`define VFS_BIT_SHR 0
// Bits that software can clear; bits 2 and 1 are always zero.
`define VFS_RW_MASK 8'hF9
`define VFS_RESET_VAL 8'h00
// Imbalance must persist this many detection cycles.
`define VFS_IMB_CYCLES 3'd7
// Temperature threshold in millivolts; no logic compares against it.
`define VFS_TEMP_MV 12'd150
`endif

/* vfs_chan.sv */
`timescale 1ns/1ps
`include "vfs_cfg.svh"
module vfs_chan #(
   parameter bit HAS_VCODE = 1'b1
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Per-channel condition and clear signals.
   vfs_chan_if.core ch
);
   import vfs_pkg::*;
   typedef struct packed {
      vfs_byte_t stat;
      logic [7:0] rep;
      logic [2:0] imb_cnt;
   } vfs_cst_t;
   vfs_cst_t st_reg;
   vfs_cst_t st_next;
   vfs_byte_t set_v;
   always_comb
   begin
      set_v = '0;
      set_v[`VFS_BIT_PS] = ch.fault_ps;
      set_v[`VFS_BIT_SNS] = ch.power_up && ch.sense_open;
      set_v[`VFS_BIT_PHL] = ch.phase_over;
      set_v[`VFS_BIT_VCR] = HAS_VCODE && ch.vcode_reset;
      // The count saturates, so a lasting imbalance sets the flag again after a clear.
      set_v[`VFS_BIT_SHR] = ch.imb_tick && (ch.imb_phases != 8'h00) && (st_reg.imb_cnt >= `VFS_IMB_CYCLES - 3'd1);
   end
   always_comb
   begin
      st_next = st_reg;
      // Write-one clears, but a condition arriving this cycle still sets.
      if (ch.clr_stb)
      begin
         st_next.stat = st_reg.stat & ~(ch.clr_mask & `VFS_RW_MASK);
      end
      st_next.stat = st_next.stat | set_v;
      // Temperature level is resampled until soft-start begins.
      if (ch.pre_soft_start)
      begin
         st_next.stat[`VFS_BIT_TMP] = ch.temp_high;
      end
      st_next.stat = st_next.stat & `VFS_RW_MASK;
      if (ch.imb_tick)
      begin
         st_next.rep = ch.imb_phases;
         if (ch.imb_phases == 8'h00)
         begin
            st_next.imb_cnt = 3'd0;
         end
         else if (st_reg.imb_cnt != `VFS_IMB_CYCLES)
         begin
            st_next.imb_cnt = st_reg.imb_cnt + 3'd1;
         end
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
   assign ch.status = st_reg.stat;
   assign ch.report = st_reg.rep;
endmodule : vfs_chan

/* vfs_chan_if.sv */
`timescale 1ns/1ps
interface vfs_chan_if;
   logic fault_ps;
   logic sense_open;
   logic phase_over;
   logic temp_high;
   logic vcode_reset;
   logic imb_tick;
   logic [7:0] imb_phases;
   logic [7:0] clr_mask;
   logic clr_stb;
   logic pre_soft_start;
   logic power_up;
   logic [7:0] status;
   logic [7:0] report;
   modport core (input fault_ps, sense_open, phase_over, temp_high, vcode_reset, imb_tick, imb_phases,
      clr_mask, clr_stb, pre_soft_start, power_up, output status, report);
   modport top (output fault_ps, sense_open, phase_over, temp_high, vcode_reset, imb_tick, imb_phases,
      clr_mask, clr_stb, pre_soft_start, power_up, input status, report);
endinterface : vfs_chan_if

/* vfs_host.sv */
`timescale 1ns/1ps
module vfs_host (
   // Clock.
   input logic clk_sys,
   // Byte transfers.
   output logic [7:0] cmd_code,
   output logic [7:0] page,
   output logic rd_stb,
   output logic wr_stb,
   output logic [7:0] wr_data,
   input logic [7:0] rd_data,
   input logic rd_valid
);
   initial
   begin
      {rd_stb, wr_stb, cmd_code, page, wr_data} = '0;
   end
   // Idle lines show the inverse of the last request, so stale values never pass.
   task automatic xfer(input logic [7:0] c, p, input logic wr, input logic [7:0] w, output logic [7:0] d,
      output logic v);
      @(negedge clk_sys);
      cmd_code = c;
      page = p;
      wr_data = w;
      {rd_stb, wr_stb} = {!wr, wr};
      @(negedge clk_sys);
      {d, v} = {rd_data, rd_valid};
      {rd_stb, wr_stb} = 2'b00;
      {cmd_code, page, wr_data} = ~{c, p, w};
   endtask : xfer
endmodule : vfs_host

/* vfs_pkg.sv */
package vfs_pkg;
   typedef logic [7:0] vfs_byte_t;
   typedef enum logic [1:0] {VFS_IDLE, VFS_WAIT, VFS_RUN} vfs_ss_t;
endpackage : vfs_pkg

/* vfs_properties.sv */
`timescale 1ns/1ps
module vfs_properties #(
   parameter int MAX_PH_A = 6,
   parameter int MAX_PH_B = 2
) (
   // Clock and reset.
   input logic clk_sys,
   input logic srst,
   // Command port and pins.
   input logic [7:0] cmd_code,
   input logic [7:0] page,
   input logic rd_stb,
   input logic [7:0] rd_data,
   input logic rd_valid,
   input logic a_fault_ps,
   input logic b_fault_ps,
   input logic [3:0] a_phase_cfg,
   input logic [3:0] b_phase_cfg,
   input logic [3:0] a_phase_run,
   input logic [3:0] b_phase_run
);
   wire rq = rd_stb && cmd_code == 8'h80;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Five held cycles cover the two sync flops and the latch.
   a_rd_answer: assert property (rq |=> rd_valid) else $error("no answer");
   a_rd_silent: assert property (!rq |=> !rd_valid) else $error("stray answer");
   a_spare_zero: assert property (rd_valid |-> rd_data[2:1] == 2'b00) else $error("spare bits set");
   a_vcode_b_zero: assert property (rd_valid && $past(page) == 8'h01 |-> !rd_data[3]) else $error("B bit 3");
   a_fault_a_seen: assert property (a_fault_ps [*5] ##0 rq && page != 8'h01 |=> rd_data[7])
      else $error("A fault missed");
   a_fault_b_seen: assert property (b_fault_ps [*5] ##0 rq && page == 8'h01 |=> rd_data[7])
      else $error("B fault missed");
   a_clamp_a: assert property ($stable(a_phase_cfg) [*5] |->
      a_phase_run == (a_phase_cfg > MAX_PH_A ? 4'(MAX_PH_A) : a_phase_cfg)) else $error("A clamp");
   a_clamp_b: assert property ($stable(b_phase_cfg) [*5] |->
      b_phase_run == (b_phase_cfg > MAX_PH_B ? 4'(MAX_PH_B) : b_phase_cfg)) else $error("B clamp");
endmodule : vfs_properties

/* vfs_top.sv */
`timescale 1ns/1ps
`include "vfs_cfg.svh"
// How it works
// - Power stage fault latches bit 7.
// - Open sense pin at power-up latches bit 6.
// - Excess phase count latches bit 5, clamps.
// - Bit 4 holds temperature level before soft-start.
// - Page 0 bit 3 latches voltage-code reset.
// - Seven consecutive imbalance cycles set bit 0.
// - Imbalanced phases readable in separate report.
// - Writing one clears a flag.
// - Page 00h A, 01h B, FFh reads A.
// - Command 80h, single byte read/write.
module vfs_top #(
   parameter int MAX_PH_A = 6,
   parameter int MAX_PH_B = 2
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Command port from the bus engine.
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] page,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic [7:0] report_a,
   output logic [7:0] report_b,
   // Channel A conditions (pins).
   input wire logic a_fault_ps,
   input wire logic a_sense_open,
   input wire logic a_temp_high,
   input wire logic a_vcode_reset,
   input wire logic a_imb_tick,
   input wire logic [7:0] a_imb_phases,
   input wire logic [3:0] a_phase_cfg,
   // Channel B conditions (pins).
   input wire logic b_fault_ps,
   input wire logic b_sense_open,
   input wire logic b_temp_high,
   input wire logic b_imb_tick,
   input wire logic [7:0] b_imb_phases,
   input wire logic [3:0] b_phase_cfg,
   // Sequencing.
   input wire logic power_up,
   input wire logic pre_soft_start,
   output logic [3:0] a_phase_run,
   output logic [3:0] b_phase_run
);
   import vfs_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; every pin input passes two flops first.
   // The command lines come from the bus engine on clk_sys and need no synchroniser.
   localparam int SW = 35;
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] pin_m;
   logic [SW-1:0] pin_s;
   // The unpacking below must list the pins in this same order.
   assign pin_raw = {
      a_fault_ps,
      a_sense_open,
      a_temp_high,
      a_vcode_reset,
      a_imb_tick,
      a_imb_phases,
      a_phase_cfg,
      b_fault_ps,
      b_sense_open,
      b_temp_high,
      b_imb_tick,
      b_imb_phases,
      b_phase_cfg,
      power_up,
      pre_soft_start
   };
   // A pin word may show a mix of old and new bits for one cycle; these pins are slow levels.
   typedef struct packed {
      logic [SW-1:0] m;
      logic [SW-1:0] s;
      logic ta;
      logic tb;
      logic [7:0] rd;
      logic rv;
      logic [3:0] pa;
      logic [3:0] pb;
      logic [7:0] ra;
      logic [7:0] rb;
   } vfs_tst_t;
   vfs_tst_t t_reg;
   vfs_tst_t t_next;
   assign pin_m = t_reg.m;
   assign pin_s = t_reg.s;
   logic sa_fps;
   logic sa_sno;
   logic sa_th;
   logic sa_vr;
   logic sa_tk;
   logic [7:0] sa_ip;
   logic [3:0] sa_pc;
   logic sb_fps;
   logic sb_sno;
   logic sb_th;
   logic sb_tk;
   logic [7:0] sb_ip;
   logic [3:0] sb_pc;
   logic s_pu;
   logic s_pss;
   assign {
      sa_fps,
      sa_sno,
      sa_th,
      sa_vr,
      sa_tk,
      sa_ip,
      sa_pc,
      sb_fps,
      sb_sno,
      sb_th,
      sb_tk,
      sb_ip,
      sb_pc,
      s_pu,
      s_pss
   } = pin_s;
   ////////////////////////////////////////////////////////////////////////////
   // Channel instances. The imbalance tick pin is a level; its rising edge is one detection cycle.
   vfs_chan_if ia();
   vfs_chan_if ib();
   logic sel_b;
   logic cmd_hit;
   logic clr_ok;
   logic [3:0] lim_a;
   logic [3:0] lim_b;
   assign lim_a = 4'(MAX_PH_A);
   assign lim_b = 4'(MAX_PH_B);
   assign sel_b = (page == `VFS_PAGE_B);
   assign cmd_hit = (cmd_code == `VFS_CMD_CODE);
   // Writing with page FFh reaches channel A only, matching reads.
   assign clr_ok = wr_stb && cmd_hit && (page == `VFS_PAGE_A || page == `VFS_PAGE_B || page == `VFS_PAGE_ALL);
   // Channel A wiring.
   assign ia.fault_ps = sa_fps;
   assign ia.sense_open = sa_sno;
   assign ia.phase_over = sa_pc > lim_a;
   assign ia.temp_high = sa_th;
   assign ia.vcode_reset = sa_vr;
   assign ia.imb_tick = sa_tk && !t_reg.ta;
   assign ia.imb_phases = sa_ip;
   assign ia.clr_mask = wr_data;
   assign ia.clr_stb = clr_ok && !sel_b;
   assign ia.pre_soft_start = s_pss;
   assign ia.power_up = s_pu;
   // Channel B wiring.
   assign ib.fault_ps = sb_fps;
   assign ib.sense_open = sb_sno;
   assign ib.phase_over = sb_pc > lim_b;
   assign ib.temp_high = sb_th;
   assign ib.vcode_reset = 1'b0;
   assign ib.imb_tick = sb_tk && !t_reg.tb;
   assign ib.imb_phases = sb_ip;
   assign ib.clr_mask = wr_data;
   assign ib.clr_stb = clr_ok && sel_b;
   assign ib.pre_soft_start = s_pss;
   assign ib.power_up = s_pu;
   vfs_chan #(.HAS_VCODE(1'b1)) u_cha (.clk_sys(clk_sys), .srst(srst), .ch(ia));
   vfs_chan #(.HAS_VCODE(1'b0)) u_chb (.clk_sys(clk_sys), .srst(srst), .ch(ib));
   ////////////////////////////////////////////////////////////////////////////
   // Single-byte read answer and phase clamp.
   always_comb
   begin
      t_next = t_reg;
      t_next.m = pin_raw;
      t_next.s = pin_m;
      t_next.ta = sa_tk;
      t_next.tb = sb_tk;
      t_next.rv = rd_stb && cmd_hit;
      // Any page other than 01h answers with channel A, which FFh requires.
      if (rd_stb && cmd_hit)
      begin
         t_next.rd = sel_b ? ib.status : ia.status;
      end
      if (sa_pc > lim_a)
      begin
         t_next.pa = lim_a;
      end
      else
      begin
         t_next.pa = sa_pc;
      end
      if (sb_pc > lim_b)
      begin
         t_next.pb = lim_b;
      end
      else
      begin
         t_next.pb = sb_pc;
      end
      t_next.ra = ia.report;
      t_next.rb = ib.report;
   end
   ////////////////////////////////////////////////////////////////////////////
   // State register; a synchronous reset clears every output.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         t_reg <= '0;
      end
      else
      begin
         t_reg <= t_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Every output comes straight from a flip-flop.
   assign rd_data = t_reg.rd;
   assign rd_valid = t_reg.rv;
   assign a_phase_run = t_reg.pa;
   assign b_phase_run = t_reg.pb;
   assign report_a = t_reg.ra;
   assign report_b = t_reg.rb;
endmodule : vfs_top

/* vfs_top_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %s %h %h", n, e, a); end end
module vfs_top_tb;
   logic clk_sys, srst, power_up, pre_soft_start, rd_stb, wr_stb, rd_valid, a_imb_tick, b_imb_tick, v;
   logic [7:0] cmd_code, page, wr_data, rd_data, report_a, report_b, a_imb_phases, b_imb_phases, d;
   logic a_fault_ps, a_sense_open, a_temp_high, a_vcode_reset, b_fault_ps, b_sense_open, b_temp_high;
   logic [3:0] a_phase_cfg, b_phase_cfg, a_phase_run, b_phase_run;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;
   vfs_top vfs_top_inst (.*);
   vfs_host vfs_host_inst (.*);
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         results();
      end
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wait_n
   task automatic chk_rd(input logic [7:0] p, input logic [7:0] e);
      vfs_host_inst.xfer(8'h80, p, 1'b0, 8'h00, d, v);
      `CHK("rd_valid", 1'b1, v)
      `CHK("status", e, d)
   endtask : chk_rd
   task automatic wr(input logic [7:0] p, input logic [7:0] w);
      vfs_host_inst.xfer(8'h80, p, 1'b1, w, d, v);
   endtask : wr
   task automatic tick(input logic [7:0] ph);
      {a_imb_phases, b_imb_phases, a_imb_tick, b_imb_tick} = {ph, ph[3:0], ph[7:4], 2'b11};
      wait_n(2);
      {a_imb_tick, b_imb_tick} = 2'b00;
      wait_n(2);
   endtask : tick
   task automatic t_idle;
      chk_rd(8'h00, 8'h00);
      vfs_host_inst.xfer(8'h81, 8'h00, 1'b0, 8'h00, d, v);
      `CHK("silent", 1'b0, v)
      $display("idle end");
   endtask : t_idle
   task automatic t_persist;
      {b_fault_ps, b_phase_cfg} = 5'h13;
      wait_n(5);
      `CHK("b_run", 4'h2, b_phase_run)
      chk_rd(8'h01, 8'hA0);
      b_phase_cfg = 4'h2;
      wait_n(5);
      wr(8'h01, 8'hFF);
      chk_rd(8'h01, 8'h80);
      b_fault_ps = 1'b0;
      wait_n(5);
      wr(8'h01, 8'h80);
      chk_rd(8'h01, 8'h00);
      chk_rd(8'h00, 8'h00);
      $display("persist end");
   endtask : t_persist
   task automatic t_flags;
      {a_fault_ps, a_sense_open, a_temp_high, a_vcode_reset, a_phase_cfg} = 8'hF7;
      wait_n(5);
      `CHK("a_run", 4'h6, a_phase_run)
      chk_rd(8'h00, 8'hF8);
      {a_fault_ps, a_sense_open, a_vcode_reset, power_up, pre_soft_start} = '0;
      wait_n(5);
      {a_temp_high, a_phase_cfg} = 5'h06;
      wait_n(5);
      chk_rd(8'h00, 8'hF8);
      chk_rd(8'hFF, 8'hF8);
      chk_rd(8'h01, 8'h00);
      wr(8'h00, 8'h06);
      chk_rd(8'h00, 8'hF8);
      wr(8'h00, 8'hFF);
      chk_rd(8'h00, 8'h00);
      $display("flags end");
   endtask : t_flags
   task automatic t_share;
      repeat (6) tick(8'h05);
      tick(8'h00);
      repeat (6) tick(8'h05);
      chk_rd(8'h00, 8'h00);
      `CHK("report_a", 8'h05, report_a)
      `CHK("report_b", 8'h50, report_b)
      tick(8'h05);
      chk_rd(8'h00, 8'h01);
      chk_rd(8'h01, 8'h01);
      wr(8'h00, 8'h01);
      chk_rd(8'h00, 8'h00);
      tick(8'h05);
      chk_rd(8'h00, 8'h01);
      $display("share end");
   endtask : t_share
   task automatic results;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   initial
   begin
      {srst, power_up, pre_soft_start, a_imb_phases, b_imb_phases, a_phase_cfg, b_phase_cfg} = 27'h700_0062;
      {a_fault_ps, a_sense_open, a_temp_high, a_vcode_reset, a_imb_tick} = '0;
      {b_fault_ps, b_sense_open, b_temp_high, b_imb_tick} = '0;
      wait_n(12);
      srst = 1'b0;
      wait_n(4);
      t_idle();
      t_persist();
      t_flags();
      t_share();
      results();
   end
endmodule : vfs_top_tb
bind vfs_top vfs_properties #(.MAX_PH_A(MAX_PH_A), .MAX_PH_B(MAX_PH_B)) vfs_properties_inst (.*);
